// File: verilog/jtid_tap.sv
// module: test access port with identification, bypass fallback and design security
module jtid_tap
   import jtid_pkg::*;
#(
   parameter bit                       HAS_BSCAN = 1'b0,
   parameter int                       BSR_LEN   = BSR_LEN_DEF,
   parameter int                       CFG_W     = CFG_W_DEF,
   parameter logic [ID_VER_W-1:0]      ID_VER    = 4'h1,       // value arbitrary
   parameter logic [ID_PART_W-1:0]     ID_PART   = 16'h1234,   // value arbitrary
   parameter logic [ID_MFG_W-1:0]      ID_MFG    = 11'h055     // value arbitrary
) (
   input  wire logic             I_CLK,
   input  wire logic             I_RST_N,
   input  wire logic             I_TCK,
   input  wire logic             I_TMS,
   input  wire logic             I_TDI,
   output logic                  O_TDO,
   output logic                  O_TDO_OE,
   output logic                  O_SECURED,
   output logic [CFG_W-1:0]      O_CFG_DATA
);

   // ----------------------------------------------------------------
   // identification word, leftmost field is the top
   // ----------------------------------------------------------------
   localparam logic [ID_LEN-1:0] ID_WORD = {ID_VER, ID_PART, ID_MFG, ID_LSB_VAL};

   logic [2:0]         pin_s;
   logic               tck_s;
   logic               tms_s;
   logic               tdi_s;
   logic               tck_prev_reg;
   logic               rise;
   logic               fall;

   jtid_state_e        state_reg,  state_next;
   logic [IR_LEN-1:0]  ir_sh_reg,  ir_sh_next;
   logic [IR_LEN-1:0]  ir_reg,     ir_next;
   logic [ID_LEN-1:0]  id_sh_reg,  id_sh_next;
   logic               byp_reg,    byp_next;
   logic [CFG_W-1:0]   cfg_sh_reg, cfg_sh_next;
   logic [BSR_LEN-1:0] bsr_reg,    bsr_next;
   logic [CFG_W-1:0]   cfg_reg,    cfg_next;
   logic               sec_reg,    sec_next;
   logic               tdo_reg,    tdo_next;
   logic               oe_reg,     oe_next;

   logic               sel_id;
   logic               sel_cfg;
   logic               sel_bsr;
   logic               dr_out;

   // ----------------------------------------------------------------
   // pin synchronisers and tck edge finding
   // ----------------------------------------------------------------
   jtid_sync #(
      .WIDTH   (3)
   ) u_sync (
      .I_CLK   (I_CLK),
      .I_RST_N (I_RST_N),
      .i_async ({I_TCK, I_TMS, I_TDI}),
      .o_sync  (pin_s)
   );

   assign tck_s = pin_s[2];
   assign tms_s = pin_s[1];
   assign tdi_s = pin_s[0];
   assign rise  = tck_s & ~tck_prev_reg;
   assign fall  = ~tck_s & tck_prev_reg;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tck_prev_reg <= 1'b0;
      end else begin
         tck_prev_reg <= tck_s;
      end
   end

   // ----------------------------------------------------------------
   // data register selection
   // ----------------------------------------------------------------
   // unknown codes fall back to bypass, as the port standard expects
   always_comb begin
      sel_id  = (ir_reg == OP_DEVICE_IDENTIFICATION);
      sel_cfg = (ir_reg == OP_CFG_PROGRAM) || (ir_reg == OP_CFG_READ);
      sel_bsr = HAS_BSCAN && ((ir_reg == OP_EXTEST) || (ir_reg == OP_SAMPLE));
      if (sel_id) begin
         dr_out = id_sh_reg[0];
      end else if (sel_cfg) begin
         dr_out = cfg_sh_reg[0];
      end else if (sel_bsr) begin
         dr_out = bsr_reg[0];
      end else begin
         dr_out = byp_reg;
      end
   end

   // ----------------------------------------------------------------
   // controller, shift paths and configuration store
   // ----------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      ir_sh_next  = ir_sh_reg;
      ir_next     = ir_reg;
      id_sh_next  = id_sh_reg;
      byp_next    = byp_reg;
      cfg_sh_next = cfg_sh_reg;
      bsr_next    = bsr_reg;
      cfg_next    = cfg_reg;
      sec_next    = sec_reg;
      tdo_next    = tdo_reg;
      oe_next     = oe_reg;
      if (rise) begin
         // actions of the state being left, then the move
         case (state_reg)
            ST_RESET: begin
               ir_next = OP_DEVICE_IDENTIFICATION;           // device_identification is the default after reset
            end
            ST_CAP_IR: begin
               ir_sh_next = IR_CAPTURE_VAL;
            end
            ST_SH_IR: begin
               ir_sh_next = {tdi_s, ir_sh_reg[IR_LEN-1:1]};
            end
            ST_UPD_IR: begin
               ir_next = ir_sh_reg;
            end
            ST_CAP_DR: begin
               if (sel_id) begin
                  id_sh_next = ID_WORD;
               end else if (sel_cfg) begin
                  // a secured part hands back zeros, never the stored data
                  cfg_sh_next = sec_reg ? '0 : cfg_reg;
               end else begin
                  byp_next = BYP_CAPTURE;
               end
            end
            ST_SH_DR: begin
               if (sel_id) begin
                  id_sh_next = {tdi_s, id_sh_reg[ID_LEN-1:1]};
               end else if (sel_cfg) begin
                  cfg_sh_next = {tdi_s, cfg_sh_reg[CFG_W-1:1]};
               end else if (sel_bsr) begin
                  bsr_next = {tdi_s, bsr_reg[BSR_LEN-1:1]};
               end else begin
                  byp_next = tdi_s;
               end
            end
            ST_UPD_DR: begin
               if (ir_reg == OP_CFG_PROGRAM) begin
                  cfg_next = cfg_sh_reg;
               end else if (ir_reg == OP_CFG_SECURE) begin
                  sec_next = 1'b1;
               end else if (ir_reg == OP_CFG_ERASE) begin
                  // besides the I_RST_N reset, only this erase clears the security bit; an OP_CFG_PROGRAM update also rewrites the store
                  cfg_next = '0;
                  sec_next = SEC_RST;
               end
            end
            default: begin
            end
         endcase
         case (state_reg)
            ST_RESET:  state_next = tms_s ? ST_RESET  : ST_IDLE;
            ST_IDLE:   state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = tms_s ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            default:   state_next = ST_RESET;
         endcase
      end
      if (fall) begin
         // tdo moves on the falling edge so the host samples it on the rise
         if (state_reg == ST_SH_IR) begin
            tdo_next = ir_sh_reg[0];
            oe_next  = 1'b1;
         end else if (state_reg == ST_SH_DR) begin
            tdo_next = dr_out;
            oe_next  = 1'b1;
         end else begin
            tdo_next = 1'b0;
            oe_next  = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   // the security bit is nonvolatile in spirit: the tap reset never touches it
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_reg  <= ST_RESET;
         ir_sh_reg  <= IR_CAPTURE_VAL;
         ir_reg     <= OP_DEVICE_IDENTIFICATION;
         id_sh_reg  <= '0;
         byp_reg    <= BYP_CAPTURE;
         cfg_sh_reg <= '0;
         bsr_reg    <= '0;
         cfg_reg    <= '0;
         sec_reg    <= SEC_RST;
         tdo_reg    <= 1'b0;
         oe_reg     <= 1'b0;
      end else begin
         state_reg  <= state_next;
         ir_sh_reg  <= ir_sh_next;
         ir_reg     <= ir_next;
         id_sh_reg  <= id_sh_next;
         byp_reg    <= byp_next;
         cfg_sh_reg <= cfg_sh_next;
         bsr_reg    <= bsr_next;
         cfg_reg    <= cfg_next;
         sec_reg    <= sec_next;
         tdo_reg    <= tdo_next;
         oe_reg     <= oe_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign O_TDO      = tdo_reg;
   assign O_TDO_OE   = oe_reg;
   assign O_SECURED  = sec_reg;
   assign O_CFG_DATA = cfg_reg;

endmodule

// File: verilog/jtid_pkg.sv
// package: constants and types of the identification and security test port
package jtid_pkg;

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   localparam int          IR_LEN         = 10;
   localparam logic [9:0]  IR_CAPTURE_VAL = 10'h001; // fixed 01 pattern in the low bits
   localparam logic [9:0]  OP_EXTEST      = 10'h000;
   localparam logic [9:0]  OP_SAMPLE      = 10'h055;
   localparam logic [9:0]  OP_DEVICE_IDENTIFICATION      = 10'h059;
   localparam logic [9:0]  OP_CFG_PROGRAM = 10'h2F4;
   localparam logic [9:0]  OP_CFG_READ    = 10'h205;
   localparam logic [9:0]  OP_CFG_SECURE  = 10'h2F9;
   localparam logic [9:0]  OP_CFG_ERASE   = 10'h2F2;
   localparam logic [9:0]  OP_BYPASS      = 10'h3FF;

   // ----------------------------------------------------------------
   // identification register layout
   // ----------------------------------------------------------------
   localparam int          ID_LEN         = 32;
   localparam int          ID_VER_POS     = 28;
   localparam int          ID_VER_W       = 4;
   localparam int          ID_PART_POS    = 12;
   localparam int          ID_PART_W      = 16;
   localparam int          ID_MFG_POS     = 1;
   localparam int          ID_MFG_W       = 11;
   localparam logic        ID_LSB_VAL     = 1'b1;

   // ----------------------------------------------------------------
   // configuration store and reset values
   // ----------------------------------------------------------------
   localparam int          CFG_W_DEF      = 16;
   localparam int          BSR_LEN_DEF    = 288;
   localparam logic        SEC_RST        = 1'b0;
   localparam logic        BYP_CAPTURE    = 1'b0;
   localparam logic [2:0]  RESET_TMS_CNT  = 3'h5;  // tms-high edges to reach reset

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jtid_state_e;

endpackage

// File: verilog/jtid_sync.sv
// module: two-flop synchroniser for pins from outside the clock domain
module jtid_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             I_CLK,
   input  wire logic             I_RST_N,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // ----------------------------------------------------------------
   // the first stage is read only by the second
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

// File: testbench/jtid_tap_properties.sv
// checker: port-level reset, security, store and timing properties of the identification test port
module jtid_tap_properties
   import jtid_pkg::*;
#(
   parameter int CFG_W = CFG_W_DEF
) (
   input wire logic             I_CLK,
   input wire logic             I_RST_N,
   input wire logic             I_TCK,
   input wire logic             I_TMS,
   input wire logic             I_TDI,
   input wire logic             O_TDO,
   input wire logic             O_TDO_OE,
   input wire logic             O_SECURED,
   input wire logic [CFG_W-1:0] O_CFG_DATA
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // ----------------------------------------------------------------
   // link activity counter
   // ----------------------------------------------------------------
   logic [3:0] idle_reg;
   logic [3:0] idle_next;
   logic       tck_reg;
   // cycles since the tck pin last moved, saturating so it never wraps
   always_comb begin
      idle_next = (I_TCK != tck_reg) ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hF};
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         idle_reg <= 4'h0;
         tck_reg  <= 1'b0;
      end else begin
         idle_reg <= idle_next;
         tck_reg  <= I_TCK;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_reset_clean: assert property ($rose(I_RST_N) |-> !O_SECURED && O_CFG_DATA == '0)
      else $error("state not clear after reset");
   a_sec_idle: assert property (idle_reg > 4'h8 |-> $stable(O_SECURED) && $stable(O_CFG_DATA))
      else $error("security or store moved without link activity");
   a_erase_both: assert property ($fell(O_SECURED) |-> O_CFG_DATA == '0)
      else $error("security cleared without clearing store");
   a_tdo_zero_off: assert property (!O_TDO_OE |-> !O_TDO)
      else $error("tdo not low while released");
   a_tdo_idle: assert property (idle_reg > 4'h8 |-> $stable(O_TDO) && $stable(O_TDO_OE))
      else $error("tdo moved without link activity");
   a_oe_after_fall: assert property ($changed(O_TDO_OE) |-> !$past(I_TCK, 2))
      else $error("tdo enable moved outside tck low");
   a_oe_stands: assert property ($rose(O_TDO_OE) |=> O_TDO_OE [*5])
      else $error("tdo enable too short");
   a_tdo_stands: assert property ($changed(O_TDO) |=> $stable(O_TDO) [*5])
      else $error("tdo bit did not stand");
endmodule

bind jtid_tap jtid_tap_properties #(.CFG_W(CFG_W)) u_jtid_tap_properties (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_TCK(I_TCK), .I_TMS(I_TMS), .I_TDI(I_TDI),
   .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_SECURED(O_SECURED), .O_CFG_DATA(O_CFG_DATA)
);

// File: testbench/jtid_host.sv
// partner: behavioural test controller that drives the link pins
module jtid_host (
   input  wire logic i_clk,
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last = 1'b0;
   logic line;
   // ----------------------------------------------------------------
   // link pins
   // ----------------------------------------------------------------
   // a released tdo shows the inverse of its last level, never a stale match
   always @(i_tdo or i_tdo_oe) begin
      if (i_tdo_oe) last = i_tdo;
   end
   assign line = i_tdo_oe ? i_tdo : ~last;
   // tck stands low between frames
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end
   // 80 ns bits on the system clock: tms and tdi move with the fall,
   // tdo read late in the high half, long after the previous fall settled it
   task automatic bits(input logic [63:0] tms, input logic [63:0] tdi, input int n,
                       output logic [63:0] tdo);
      tdo = '0;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_tck <= 1'b0;
         o_tms <= tms[i];
         o_tdi <= tdi[i];
         repeat (4) @(posedge i_clk);
         o_tck <= 1'b1;
         repeat (3) @(posedge i_clk);
         @(negedge i_clk);
         tdo[i] = line;
      end
      // close the last bit so tck stands low between frames
      @(posedge i_clk);
      o_tck <= 1'b0;
   endtask
endmodule

// File: testbench/test_jtag_device_identification_and_security.sv
// testbench: identification, bypass fallback and security of the test port
module test_jtag_device_identification_and_security
   import jtid_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0]  VER     = 4'h3;     // value arbitrary
   localparam logic [15:0] PART    = 16'hB00C; // value arbitrary
   localparam logic [10:0] MFG     = 11'h2A6;  // value arbitrary
   localparam logic [31:0] ID_WORD = {VER, PART, MFG, 1'b1};
   typedef struct {
      logic [9:0]  op;
      int          n;
      logic [63:0] din;
      logic [63:0] exp;
   } jtid_row_s;
   // ----------------------------------------------------------------
   // instruction table: opcode, length, shifted in, expected out
   // ----------------------------------------------------------------
   jtid_row_s   rows [6] = '{
      '{OP_DEVICE_IDENTIFICATION, 32, 64'h0, 64'(ID_WORD)},
      '{OP_BYPASS, 8, 64'hA5, 64'h4A},
      '{OP_EXTEST, 8, 64'h3C, 64'h78},
      '{OP_SAMPLE, 8, 64'h81, 64'h02},
      '{10'h1AB, 8, 64'hFF, 64'hFE},
      '{OP_CFG_READ, 16, 64'h0, 64'hC3A5}
   };
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo;
   logic        oe;
   logic        sec;
   logic [15:0] cfg;
   logic [63:0] q;
   int          fails = 0;
   int          tests_run = 0;
   // system clock, 100 MHz
   always #5 clk = ~clk;
   jtid_tap #(.ID_VER(VER), .ID_PART(PART), .ID_MFG(MFG)) u_jtid_tap (
      .I_CLK(clk), .I_RST_N(rst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
      .O_TDO(tdo), .O_TDO_OE(oe), .O_SECURED(sec), .O_CFG_DATA(cfg));
   jtid_host u_jtid_host (
      .i_clk(clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(oe));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // idle to idle instruction load, capture pattern read back on the way
   task automatic ir(input logic [9:0] op);
      u_jtid_host.bits(64'h6003, {50'h0, op, 4'h0}, 16, q);
      chk(64'(q[13:4]), 64'h001);
   endtask
   // idle to idle data scan of n bits, lsb first
   task automatic dr(input logic [63:0] din, input int n);
      u_jtid_host.bits((64'h3 << (n + 2)) | 64'h1, din << 3, n + 5, q);
      q = (q >> 3) & ((64'h1 << n) - 64'h1);
   endtask
   // reset, table walk, then security and erase by hand
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #3;
      chk(64'({oe, sec, cfg}), 64'h0);
      u_jtid_host.bits(64'h1F, 64'h0, 6, q);
      ir(OP_CFG_PROGRAM);
      dr(64'hC3A5, 16);
      chk(64'(cfg), 64'hC3A5);
      foreach (rows[i]) begin
         ir(rows[i].op);
         dr(rows[i].din, rows[i].n);
         chk(q, rows[i].exp);
      end
      ir(OP_CFG_SECURE);
      dr(64'h0, 16);
      ir(OP_CFG_READ);
      dr(64'h0, 16);
      chk(q, 64'h0);
      // tap reset keeps the secret and falls back to identification
      u_jtid_host.bits(64'h1F, 64'h0, 6, q);
      dr(64'h0, 32);
      chk(q, 64'(ID_WORD));
      chk(64'({sec, cfg}), 64'h1C3A5);
      ir(OP_CFG_ERASE);
      dr(64'h0, 16);
      chk(64'({sec, cfg}), 64'h0);
      // second reset in mid-run: port idle, identification selected again
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #3;
      chk(64'({oe, sec, cfg}), 64'h0);
      u_jtid_host.bits(64'h0, 64'h0, 1, q);
      dr(64'h0, 32);
      chk(q, 64'(ID_WORD));
      conclude;
   end
endmodule
